// file: core/pch_defines.svh
`ifndef PCH_DEFINES_SVH
`define PCH_DEFINES_SVH

// Configuration byte offsets
`define PCH_OFF_DEVID 8'h02
`define PCH_OFF_HDR 8'h0e
`define PCH_OFF_ROM 8'h30
`define PCH_OFF_PWR 8'h57
`define PCH_WORD_MASK 8'hfc

// Fixed read values
`define PCH_HDR_KIND 8'h00
`define PCH_PWR_RESERVED 8'h00
`define PCH_UNMAPPED 32'h0000_0000
`define PCH_ROM_RSVD_READ 14'h0000

// Power data selector: codes from this one upward are reserved
`define PCH_PWR_SEL_LIMIT 4'h8

// Expansion ROM register reset values
`define PCH_ROM_EN_RESET 1'b0
`define PCH_ROM_BASE_RESET 17'h0_0000

`endif

// file: core/pch_pkg.sv
package pch_pkg;

  // Register state of the configuration top
  typedef struct packed {
    logic cfg_ack;
    logic [31:0] cfg_rdata;
    logic rom_en;
    logic [16:0] rom_base;
  } pch_top_state_t;

  // Registered outcome of the ROM window decoder
  typedef struct packed {
    logic decode_en;
    logic hit;
  } pch_dec_state_t;

endpackage

// file: core/pch_rom_if.sv
`timescale 1ns/1ps
`default_nettype none

interface pch_rom_if;
  logic [16:0] base;
  logic en;
  logic size_sel;
  logic mem_space;
  logic d0;
  logic mem_req;
  logic [31:0] mem_addr;
  logic decode_en;
  logic hit;

  modport cfg (
    output base, en, size_sel, mem_space, d0, mem_req, mem_addr,
    input decode_en, hit
  );

  modport dec (
    input base, en, size_sel, mem_space, d0, mem_req, mem_addr,
    output decode_en, hit
  );
endinterface // pch_rom_if

`default_nettype wire

// file: core/pch_rom_decode.sv
`timescale 1ns/1ps
`default_nettype none

module pch_rom_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // ROM window control and memory address phase
  pch_rom_if.dec ifc
);

  pch_pkg::pch_dec_state_t st;
  pch_pkg::pch_dec_state_t next_st;
  logic gate;
  logic upper_match;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    // [RULE5] ROM decode gating
    // [RULE10] Needs D0 too
    gate = ifc.en && ifc.mem_space && ifc.d0;
    upper_match = ifc.mem_addr[31:16] == ifc.base[16:1];
    next_st.decode_en = gate;
    // [RULE4] Disabled means no claim
    // Small window compares bit 15 too; large window ignores it
    next_st.hit = gate && ifc.mem_req && upper_match &&
      (ifc.size_sel || (ifc.mem_addr[15] == ifc.base[0]));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ifc.decode_en = st.decode_en;
  assign ifc.hit = st.hit;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_rom_off_idle: assert property ( // [RULE4]
    !ifc.en |=> !ifc.hit && !ifc.decode_en)
    else $error("ROM window active with decode enable clear");

  chk_rom_mem_gate: assert property ( // [RULE5]
    ifc.hit |-> $past(ifc.en) && $past(ifc.mem_space) && $past(ifc.mem_req))
    else $error("ROM claim without decode and memory enables");

  chk_rom_d0_gate: assert property ( // [RULE10]
    !ifc.d0 |=> !ifc.decode_en && !ifc.hit)
    else $error("ROM window active outside D0");

endmodule // pch_rom_decode

`default_nettype wire

// file: core/pch_cfg_top.sv
// Behaviour
// [RULE1] Power byte: figure for 0-7, else zero
// [RULE2] Software scales power byte by scale field
// [RULE3] Fixed 16-bit identifier at offset 0x02
// [RULE4] ROM enable clear: no ROM decoding
// [RULE5] ROM decode needs enable and memory space
// [RULE6] Size select clear: bits 31-15 writable
// [RULE7] Size select set: bit 15 held zero
// [RULE8] Reserved ROM bits 14-1 ignored, read zero
// [RULE9] Header byte at 0x0E reads zero
// [RULE10] ROM decode also requires D0 state
// [RULE11] Access by configuration cycles; read-only ignores writes
`timescale 1ns/1ps
`default_nettype none
`include "pch_defines.svh"

module pch_cfg_top #(
  // Identifier value is arbitrary
  parameter logic [15:0] DEVICE_ID = 16'h5a5a,
  // Power figures for selector codes 7..0, one byte each, low code lowest
  parameter logic [63:0] POWER_FIGURES = 64'h0000_0000_0000_0000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration cycle port
  input wire logic cfg_req,
  input wire logic cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  // Bits held by neighbouring registers
  input wire logic memory_space_enable,
  input wire logic power_state_d0,
  input wire logic rom_size_select,
  input wire logic [3:0] power_data_select,
  // Expansion ROM memory address phase
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output logic rom_window_open,
  output logic rom_claim
);

  pch_pkg::pch_top_state_t st;
  pch_pkg::pch_top_state_t next_st;
  pch_rom_if rom_ifc ();

  logic hit_devid;
  logic hit_hdr;
  logic hit_rom;
  logic hit_pwr;
  logic [7:0] power_byte;
  logic [5:0] fig_idx;

  //////////////////////////////////////////////////////////////////////////
  // Word-aligned address compare
  function automatic logic word_hit(input logic [7:0] addr,
                                    input logic [7:0] off);
    word_hit = (addr & `PCH_WORD_MASK) == (off & `PCH_WORD_MASK);
  endfunction

  always_comb begin
    hit_devid = word_hit(cfg_addr, `PCH_OFF_DEVID);
    hit_hdr = word_hit(cfg_addr, `PCH_OFF_HDR);
    hit_rom = word_hit(cfg_addr, `PCH_OFF_ROM);
    hit_pwr = word_hit(cfg_addr, `PCH_OFF_PWR);
  end

  //////////////////////////////////////////////////////////////////////////
  // Power readout byte
  always_comb begin
    fig_idx = {power_data_select[2:0], 3'b000};
    // [RULE1] Selector picks figure
    if (power_data_select < `PCH_PWR_SEL_LIMIT) begin
      power_byte = POWER_FIGURES[fig_idx +: 8];
    end else begin
      power_byte = `PCH_PWR_RESERVED;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state: read answer and ROM register writes
  always_comb begin
    next_st = st;
    next_st.cfg_ack = cfg_req;
    next_st.cfg_rdata = `PCH_UNMAPPED;

    // [RULE11] Reads by configuration cycle
    if (cfg_req && !cfg_we) begin
      if (hit_devid) begin
        // [RULE3] Fixed identifier word
        next_st.cfg_rdata[31:16] = DEVICE_ID;
      end else if (hit_hdr) begin
        // [RULE9] Single-function header kind
        next_st.cfg_rdata[23:16] = `PCH_HDR_KIND;
      end else if (hit_rom) begin
        // [RULE8] Reserved bits read zero
        next_st.cfg_rdata = {st.rom_base, `PCH_ROM_RSVD_READ, st.rom_en};
      end else if (hit_pwr) begin
        next_st.cfg_rdata[31:24] = power_byte;
      end
    end

    // [RULE11] Only ROM register takes writes
    if (cfg_req && cfg_we && hit_rom) begin
      if (cfg_be[0]) begin
        next_st.rom_en = cfg_wdata[0];
      end
      // [RULE6] Bit 15 writable when small
      if (cfg_be[1] && !rom_size_select) begin
        next_st.rom_base[0] = cfg_wdata[15];
      end
      if (cfg_be[2]) begin
        next_st.rom_base[8:1] = cfg_wdata[23:16];
      end
      if (cfg_be[3]) begin
        next_st.rom_base[16:9] = cfg_wdata[31:24];
      end
    end

    // [RULE7] Large window holds bit 15
    if (rom_size_select) begin
      next_st.rom_base[0] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.cfg_ack <= 1'b0;
      st.cfg_rdata <= `PCH_UNMAPPED;
      st.rom_en <= `PCH_ROM_EN_RESET;
      st.rom_base <= `PCH_ROM_BASE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_ack = st.cfg_ack;
  assign cfg_rdata = st.cfg_rdata;

  //////////////////////////////////////////////////////////////////////////
  // Expansion ROM window decoder
  assign rom_ifc.base = st.rom_base;
  assign rom_ifc.en = st.rom_en;
  assign rom_ifc.size_sel = rom_size_select;
  assign rom_ifc.mem_space = memory_space_enable;
  assign rom_ifc.d0 = power_state_d0;
  assign rom_ifc.mem_req = mem_req;
  assign rom_ifc.mem_addr = mem_addr;

  pch_rom_decode u_rom_decode (
    .clk (clk),
    .rst (rst),
    .ifc (rom_ifc.dec)
  );

  assign rom_window_open = rom_ifc.decode_en;
  assign rom_claim = rom_ifc.hit;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_read(logic [7:0] off);
    cfg_req && !cfg_we && word_hit(cfg_addr, off);
  endsequence

  sequence s_write(logic [7:0] off);
    cfg_req && cfg_we && word_hit(cfg_addr, off);
  endsequence

  chk_ack_timing: assert property ( // [RULE11]
    cfg_req |=> cfg_ack)
    else $error("Configuration cycle not answered next cycle");

  chk_power_reserved: assert property ( // [RULE1]
    s_read(`PCH_OFF_PWR) ##0 power_data_select[3]
      |=> cfg_rdata[31:24] == `PCH_PWR_RESERVED)
    else $error("Reserved power selector read non-zero");

  chk_power_figure: assert property ( // [RULE1]
    s_read(`PCH_OFF_PWR) ##0 !power_data_select[3]
      |=> cfg_rdata[31:24] ==
          POWER_FIGURES[{$past(power_data_select[2:0]), 3'b000} +: 8])
    else $error("Power byte does not match selected figure");

  chk_devid_value: assert property ( // [RULE3]
    s_read(`PCH_OFF_DEVID) |=> cfg_rdata[31:16] == DEVICE_ID)
    else $error("Identifier word wrong");

  chk_devid_nowrite: assert property ( // [RULE11]
    s_write(`PCH_OFF_DEVID) ##1 s_read(`PCH_OFF_DEVID)
      |=> cfg_rdata[31:16] == DEVICE_ID)
    else $error("Identifier word changed by a write");

  chk_header_zero: assert property ( // [RULE9]
    s_read(`PCH_OFF_HDR) |=> cfg_rdata[23:16] == `PCH_HDR_KIND)
    else $error("Header kind byte not zero");

  chk_rom_bit15_write: assert property ( // [RULE6]
    s_write(`PCH_OFF_ROM) ##0 cfg_be[1] && !rom_size_select
      |=> st.rom_base[0] == $past(cfg_wdata[15]))
    else $error("ROM base bit 15 not written");

  chk_rom_bit15_zero: assert property ( // [RULE7]
    rom_size_select |=> !st.rom_base[0])
    else $error("ROM base bit 15 not held at zero");

  chk_rom_reserved: assert property ( // [RULE8]
    s_read(`PCH_OFF_ROM) |=> cfg_rdata[14:1] == `PCH_ROM_RSVD_READ)
    else $error("Reserved ROM bits read non-zero");

  chk_rom_en_write: assert property ( // [RULE4]
    s_write(`PCH_OFF_ROM) ##0 cfg_be[0]
      |=> st.rom_en == $past(cfg_wdata[0]) ##1 rom_window_open ==
          ($past(st.rom_en) && $past(memory_space_enable) &&
           $past(power_state_d0)))
    else $error("ROM decode enable not honoured");

  chk_reset_clear: assert property (disable iff (1'b0) // [RULE4]
    rst |=> !cfg_ack && cfg_rdata == `PCH_UNMAPPED &&
      st.rom_en == `PCH_ROM_EN_RESET && st.rom_base == `PCH_ROM_BASE_RESET &&
      !rom_window_open && !rom_claim)
    else $error("Registers not cleared by reset");

  chk_ack_only_req: assert property ( // [RULE11]
    cfg_ack |-> $past(cfg_req))
    else $error("Answer without a configuration cycle");

  chk_rdata_idle: assert property ( // [RULE11]
    !cfg_ack |-> cfg_rdata == `PCH_UNMAPPED)
    else $error("Read data not zero outside an answer");

  chk_write_no_data: assert property ( // [RULE11]
    cfg_req && cfg_we |=> cfg_rdata == `PCH_UNMAPPED)
    else $error("Write answered with read data");

  chk_unmapped_zero: assert property ( // [RULE11]
    cfg_req && !cfg_we && !(hit_devid || hit_hdr || hit_rom || hit_pwr)
      |=> cfg_rdata == `PCH_UNMAPPED)
    else $error("Unmapped read returned data");

  chk_devid_low_zero: assert property ( // [RULE3]
    s_read(`PCH_OFF_DEVID) |=> cfg_rdata[15:0] == 16'h0000)
    else $error("Identifier word low half not zero");

  chk_header_word: assert property ( // [RULE9]
    s_read(`PCH_OFF_HDR) |=> cfg_rdata == `PCH_UNMAPPED)
    else $error("Header word not all zero");

  chk_power_low_zero: assert property ( // [RULE1]
    s_read(`PCH_OFF_PWR) |=> cfg_rdata[23:0] == 24'h00_0000)
    else $error("Power word low bytes not zero");

  chk_rom_read_value: assert property ( // [RULE8]
    s_read(`PCH_OFF_ROM) |=> cfg_rdata ==
      {$past(st.rom_base), `PCH_ROM_RSVD_READ, $past(st.rom_en)})
    else $error("ROM register read does not match stored value");

  sequence s_rom_lane(int lane);
    s_write(`PCH_OFF_ROM) ##0 cfg_be[lane];
  endsequence

  chk_rom_top_lane: assert property ( // [RULE6]
    s_rom_lane(3) |=> st.rom_base[16:9] == $past(cfg_wdata[31:24]))
    else $error("ROM base bits 31-24 not written");

  chk_rom_mid_lane: assert property ( // [RULE6]
    s_rom_lane(2) |=> st.rom_base[8:1] == $past(cfg_wdata[23:16]))
    else $error("ROM base bits 23-16 not written");

  chk_rom_en_keep: assert property ( // [RULE4]
    s_write(`PCH_OFF_ROM) ##0 !cfg_be[0] |=> $stable(st.rom_en))
    else $error("ROM decode enable changed without its lane");

  chk_rom_bit15_ignore: assert property ( // [RULE7]
    s_rom_lane(1) ##0 rom_size_select |=> !st.rom_base[0])
    else $error("Write reached ROM base bit 15 in large window");

  chk_rom_base_keep: assert property ( // [RULE11]
    !(cfg_req && cfg_we && hit_rom) && !rom_size_select
      |=> $stable(st.rom_base) && $stable(st.rom_en))
    else $error("ROM register changed without a write");

  chk_window_gate: assert property ( // [RULE10]
    rom_window_open |-> $past(st.rom_en) && $past(memory_space_enable) &&
      $past(power_state_d0))
    else $error("Window open without enable, memory space and D0");

  chk_window_open: assert property ( // [RULE5]
    st.rom_en && memory_space_enable && power_state_d0 |=> rom_window_open)
    else $error("Window closed although all enables are set");

  chk_claim_window: assert property ( // [RULE4]
    rom_claim |-> rom_window_open)
    else $error("ROM claim outside an open window");

  chk_claim_address: assert property ( // [RULE5]
    rom_claim |-> $past(mem_addr[31:16]) == $past(st.rom_base[16:1]))
    else $error("ROM claim outside the base address range");

endmodule // pch_cfg_top

`default_nettype wire

// file: bench/pch_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module pch_host_model (
  // Clock
  input wire logic clk,
  // Configuration cycle port
  output logic cfg_req,
  output logic cfg_we,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  initial begin
    cfg_req = 1'b0;
    cfg_we = 1'b0;
    cfg_addr = 8'hff;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
  end

  // Config cycles; power byte handed back unscaled
  task automatic xfer(input logic we, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] be,
      output logic [31:0] q, output logic ok);
    int n;
    @(negedge clk);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_be = be;
    // Reserved ROM bits go out as zero
    cfg_wdata = (a[7:2] == 6'h0c) ? (d & 32'hffff_8001) : d;
    @(negedge clk);
    cfg_req = 1'b0;
    cfg_addr = ~a;
    cfg_be = ~be;
    cfg_wdata = ~cfg_wdata;
    ok = 1'b0;
    q = 32'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      if (cfg_ack === 1'b1) begin
        ok = 1'b1;
        q = cfg_rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask
endmodule // pch_host_model

`default_nettype wire

// file: bench/test_pci_config_header_subset.sv
`timescale 1ns/1ps
`default_nettype none

module test_pci_config_header_subset;
  localparam logic [15:0] DEV = 16'h5a5a;
  localparam logic [63:0] FIG = 64'h8877_6655_4433_2211;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mem_sp = 1'b0;
  logic d0 = 1'b0;
  logic size = 1'b0;
  logic [3:0] psel = 4'h0;
  logic mem_req = 1'b0;
  logic [31:0] mem_addr = 32'h0;
  logic req, we, ack, win, claim;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rd_q;
  logic [16:0] m_base = 17'h0;
  logic m_en = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'h6b4cdbc4;

  always #20 clk = ~clk;

  pch_host_model i_host (.clk(clk), .cfg_req(req), .cfg_we(we),
    .cfg_addr(addr), .cfg_be(be), .cfg_wdata(wd), .cfg_ack(ack),
    .cfg_rdata(rd_q));

  pch_cfg_top #(.DEVICE_ID(DEV), .POWER_FIGURES(FIG)) i_dut (
    .clk(clk), .rst(rst), .cfg_req(req), .cfg_we(we), .cfg_addr(addr),
    .cfg_be(be), .cfg_wdata(wd), .cfg_ack(ack), .cfg_rdata(rd_q),
    .memory_space_enable(mem_sp), .power_state_d0(d0),
    .rom_size_select(size), .power_data_select(psel),
    .mem_req(mem_req), .mem_addr(mem_addr), .rom_window_open(win),
    .rom_claim(claim));

  task automatic chk(input logic [31:0] got, exp, input logic ok);
    total_checks++;
    if (!ok || got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic ok;
    i_host.xfer(1'b0, a, 32'h0, 4'h0, q, ok);
    chk(q, exp, ok);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] b);
    logic [31:0] q;
    logic ok;
    i_host.xfer(1'b1, a, d, b, q, ok);
    chk({31'h0, ok}, 32'h1, 1'b1);
    if (a[7:2] == 6'h0c) begin
      if (b[0]) m_en = d[0];
      if (b[1] && !size) m_base[0] = d[15];
      if (b[2]) m_base[8:1] = d[23:16];
      if (b[3]) m_base[16:9] = d[31:24];
    end
  endtask

  task automatic rom_probe(input logic [31:0] a);
    logic open, hit;
    repeat (2) @(negedge clk);
    open = m_en & mem_sp & d0;
    chk({31'h0, win}, {31'h0, open}, 1'b1);
    mem_req = 1'b1;
    mem_addr = a;
    hit = size ? (a[31:16] == m_base[16:1]) : (a[31:15] == m_base);
    @(negedge clk);
    chk({31'h0, claim}, {31'h0, open & hit}, 1'b1);
    mem_req = 1'b0;
    mem_addr = ~a;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] r, d, f;
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd(8'h30, 32'h0);
    rd(8'h0e, 32'h0);
    rd(8'h02, {DEV, 16'h0});
    rd(8'h10, 32'h0);
    wr(8'h00, 32'hffff_ffff, 4'hf);
    wr(8'h0c, 32'hffff_ffff, 4'hf);
    rd(8'h00, {DEV, 16'h0});
    rd(8'h0c, 32'h0);
    for (int s = 0; s < 16; s++) begin
      psel = s[3:0];
      rd(8'h57, (s < 8) ? {FIG[8*s +: 8], 24'h0} : 32'h0);
    end
    for (int k = 0; k < 32; k++) begin
      r = $random(seed);
      d = $random(seed);
      d[0] = r[4] | r[5];
      mem_sp = r[0];
      d0 = r[1];
      if (r[2] && !size) m_base[0] = 1'b0;
      size = r[2];
      wr(8'h30, d, r[9:6] | {3'h0, k[0]});
      rd(8'h30, {m_base, 14'h0, m_en});
      // Flip bit 14 (inside), bit 15 (size dependent) or bit 16 (outside)
      f = r[3] ? 32'h4000 : (r[10] ? 32'h8000 : 32'h1_0000);
      rom_probe({m_base, 15'h0} ^ f);
    end
    // Mid-run reset clears the ROM register and closes the window
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    m_base = 17'h0;
    m_en = 1'b0;
    rd(8'h30, 32'h0);
    rom_probe(32'h0);
    close_out();
  end
endmodule // test_pci_config_header_subset

`default_nettype wire
